// ---- rtl/afeio_pkg.sv ----
// afeio_pkg: constants, configuration and strap types of the serial port and clocking block.
// assumes one system clock; all pin inputs arrive synchronous to it.
package afeio_pkg;

  // ----------------------------------------------------------------
  // serial framing
  // ----------------------------------------------------------------
  localparam int CMD_BITS = 8;
  localparam int DATA_BITS = 8;
  localparam int CMD_RW_POS = 0;
  localparam logic CMD_IS_READ = 1'b1;
  localparam logic [2:0] BIT_CNT_LAST = 3'h7;
  localparam int FRAME_BITS = 24;
  localparam logic [4:0] FRAME_BITS_CNT = 5'h18;

  // ----------------------------------------------------------------
  // clock chain
  // ----------------------------------------------------------------
  localparam logic [1:0] DIGITAL_SAMPLE_CLOCK_DIV_LAST = 2'h3;
  localparam logic [1:0] READY_LOW_LAST = 2'h1;
  localparam int OSR_W = 13;
  localparam logic [OSR_W-1:0] OSR_MIN = 13'h0020;

  // ----------------------------------------------------------------
  // types
  // ----------------------------------------------------------------
  typedef struct packed {
    logic ready_pin_float_select;
    logic external_clock_select;
    logic [1:0] prescale;
    logic [2:0] osr;
  } afeio_cfg_t;

  localparam afeio_cfg_t CFG_DEFAULT = '{
    ready_pin_float_select: 1'b0,
    external_clock_select: 1'b1,
    prescale: 2'h0,
    osr: 3'h3
  };

  typedef struct packed {
    logic strap_gain_bit_hi;
    logic strap_gain_bit_lo;
    logic boost;
    logic strap_oversample_bit_hi;
    logic strap_oversample_bit_lo;
  } afeio_strap_t;

  localparam afeio_strap_t STRAP_RESET = 5'h00;

  typedef enum logic [3:0] {
    SP_IDLE = 4'h1,
    SP_CMD = 4'h2,
    SP_WRITE = 4'h4,
    SP_READ = 4'h8
  } afeio_spi_state_t;

  // ----------------------------------------------------------------
  // decoders
  // ----------------------------------------------------------------
  function automatic logic [2:0] afeio_prescale_last(input logic [1:0] code);
    case (code)
      2'h0: afeio_prescale_last = 3'h0;
      2'h1: afeio_prescale_last = 3'h1;
      2'h2: afeio_prescale_last = 3'h3;
      default: afeio_prescale_last = 3'h7;
    endcase
  endfunction : afeio_prescale_last

  function automatic logic [OSR_W-1:0] afeio_osr_last(input logic [2:0] code);
    afeio_osr_last = (OSR_MIN << code) - 13'h0001;
  endfunction : afeio_osr_last

endpackage : afeio_pkg

// ---- rtl/afeio_spi_port.sv ----
// afeio_spi_port: command, write and read shifting of the serial-peripheral interface.
// assumes sck edges arrive as one-cycle pulses and the top gates enable with mode and reset.
module afeio_spi_port
  import afeio_pkg::*;
(
  input wire logic clk,
  input wire logic rst_n,
  input wire logic enable,
  input wire logic cs_n,
  input wire logic sck_rise,
  input wire logic sck_fall,
  input wire logic sdi,
  input wire logic [DATA_BITS-1:0] rd_data,
  output logic sdo,
  output logic sdo_oe_n,
  output logic cmd_valid,
  output logic [CMD_BITS-1:0] cmd_byte,
  output logic wr_valid,
  output logic [DATA_BITS-1:0] wr_byte,
  output logic rd_req
);

  afeio_spi_state_t state_r;
  logic [2:0] bit_cnt_r;
  logic [DATA_BITS-1:0] in_sh_r;
  logic [DATA_BITS-1:0] out_sh_r;
  logic active;
  logic [DATA_BITS-1:0] in_nxt;

  assign active = enable & ~cs_n;
  assign in_nxt = {in_sh_r[DATA_BITS-2:0], sdi};

  // ----------------------------------------------------------------
  // transfer sequencing
  // ----------------------------------------------------------------
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      state_r <= SP_IDLE;
      bit_cnt_r <= 3'h0;
      in_sh_r <= 8'h00;
      out_sh_r <= 8'h00;
      sdo <= 1'b0;
      sdo_oe_n <= 1'b1;
      cmd_valid <= 1'b0;
      cmd_byte <= 8'h00;
      wr_valid <= 1'b0;
      wr_byte <= 8'h00;
      rd_req <= 1'b0;
    end
    else
    begin
      cmd_valid <= 1'b0;
      wr_valid <= 1'b0;
      rd_req <= 1'b0;
      if (!active)
      begin
        state_r <= SP_IDLE;
        bit_cnt_r <= 3'h0;
        sdo_oe_n <= 1'b1;
      end
      else
      begin
        case (state_r)
          SP_IDLE, SP_CMD:
          begin
            state_r <= SP_CMD;
            // falling edges are ignored here, so both clock modes work
            if (sck_rise)
            begin
              in_sh_r <= in_nxt;
              bit_cnt_r <= bit_cnt_r + 3'h1;
              if (bit_cnt_r == BIT_CNT_LAST)
              begin
                cmd_valid <= 1'b1;
                cmd_byte <= in_nxt;
                if (in_nxt[CMD_RW_POS] == CMD_IS_READ)
                begin
                  state_r <= SP_READ;
                  rd_req <= 1'b1;
                end
                else
                begin
                  state_r <= SP_WRITE;
                end
              end
            end
          end
          SP_WRITE:
          begin
            if (sck_rise)
            begin
              in_sh_r <= in_nxt;
              bit_cnt_r <= bit_cnt_r + 3'h1;
              if (bit_cnt_r == BIT_CNT_LAST)
              begin
                wr_valid <= 1'b1;
                wr_byte <= in_nxt;
              end
            end
          end
          SP_READ:
          begin
            // input is not sampled while reading: the link is half-duplex
            if (sck_fall)
            begin
              sdo_oe_n <= 1'b0;
              bit_cnt_r <= bit_cnt_r + 3'h1;
              if (bit_cnt_r == 3'h0)
              begin
                sdo <= rd_data[DATA_BITS-1];
                out_sh_r <= {rd_data[DATA_BITS-2:0], 1'b0};
              end
              else
              begin
                sdo <= out_sh_r[DATA_BITS-1];
                out_sh_r <= {out_sh_r[DATA_BITS-2:0], 1'b0};
              end
              if (bit_cnt_r == BIT_CNT_LAST)
              begin
                rd_req <= 1'b1;
              end
            end
          end
          default:
          begin
            state_r <= SP_IDLE;
          end
        endcase
      end
    end
  end

endmodule : afeio_spi_port

// ---- rtl/afeio_top.sv ----
// afeio_top: pin-level serial port, interface selection, straps and clock chain of the front end.
// assumes every pin input is synchronous to CLK and that sck toggles at most every other cycle.
//
// How it works
// - ready pin driven high or floats per select
// - one low ready pulse per conversion
// - pulse half sample period, output-rate repeat
// - ready pulse ignores serial activity
// - two-wire mode reuses pins as straps
// - straps captured on mode entry and on watchdog in two-wire mode
// - external select picks oscillator or direct clock
// - oscillator pin b selects interface
// - interface pin sampled only after resets
// - prescale field divides timebase by 1/2/4/8
// - chip select frames transfers
// - hard reset blocks serial communication
// - both clock modes accepted
// - sample on rising, shift out falling
// - serial clock independent of master timebase in spi mode; it is the timebase in two-wire mode
// - serial output floats except during reads and in two-wire mode
// - link is half-duplex
// - transfer opens with an 8-bit command
// - two-wire frame sent at every ready event
// - data input ignored while deselected
// - sample clock is modulator clock over four
// - output rate is sample clock over ratio
// - hard reset restores defaults, stops clocks
module afeio_top
  import afeio_pkg::*;
(
  input wire logic CLK,
  input wire logic RESET_N,
  input wire afeio_cfg_t CONFIG,
  input wire logic OSC_TICK,
  input wire logic OSC_A_IN,
  input wire logic OSC_B_IN,
  input wire logic HARD_RESET_N,
  input wire logic WDT_RESET,
  input wire logic CS_N,
  input wire logic SCK,
  input wire logic SDI,
  input wire logic READY_IN,
  input wire logic [FRAME_BITS-1:0] FRAME_DATA,
  input wire logic [DATA_BITS-1:0] RD_DATA,
  output logic READY_OUT,
  output logic READY_OE_N,
  output logic SDO_OUT,
  output logic SDO_OE_N,
  output logic OSC_ENABLE,
  output logic TWO_WIRE_MODE,
  output afeio_strap_t STRAPS,
  output logic REGS_DEFAULT,
  output logic MODULATOR_TICK,
  output logic SAMPLE_TICK,
  output logic OUTPUT_RATE_TICK,
  output logic FRAME_LOAD,
  output logic CMD_VALID,
  output logic [CMD_BITS-1:0] CMD_BYTE,
  output logic WR_VALID,
  output logic [DATA_BITS-1:0] WR_BYTE,
  output logic RD_REQ
);

  // ----------------------------------------------------------------
  // reset release
  // ----------------------------------------------------------------
  logic rst_meta_r;
  logic rst_n;

  always_ff @(posedge CLK or negedge RESET_N)
  begin
    if (!RESET_N)
    begin
      rst_meta_r <= 1'b0;
      rst_n <= 1'b0;
    end
    else
    begin
      rst_meta_r <= 1'b1;
      rst_n <= rst_meta_r;
    end
  end

  // ----------------------------------------------------------------
  // pin edge detection
  // ----------------------------------------------------------------
  logic sck_d_r;
  logic osca_d_r;
  logic hrst_d_r;
  logic sck_rise;
  logic sck_fall;
  logic osca_rise;

  always_ff @(posedge CLK or negedge rst_n)
  begin
    if (!rst_n)
    begin
      sck_d_r <= 1'b0;
      osca_d_r <= 1'b0;
      hrst_d_r <= 1'b1;
    end
    else
    begin
      sck_d_r <= SCK;
      osca_d_r <= OSC_A_IN;
      hrst_d_r <= HARD_RESET_N;
    end
  end

  assign sck_rise = SCK & ~sck_d_r;
  assign sck_fall = ~SCK & sck_d_r;
  assign osca_rise = OSC_A_IN & ~osca_d_r;

  // ----------------------------------------------------------------
  // interface mode and hard reset
  // ----------------------------------------------------------------
  logic two_wire_r;
  logic mode_pending_r;
  logic hard_rst;
  logic hard_release;
  logic enter_two_wire;
  afeio_cfg_t cfg_eff;

  // the reset pin is a strap in two-wire mode, so it resets only in spi mode
  assign hard_rst = ~two_wire_r & ~HARD_RESET_N;
  assign hard_release = ~two_wire_r & HARD_RESET_N & ~hrst_d_r;
  assign cfg_eff = hard_rst ? CFG_DEFAULT : CONFIG;
  assign enter_two_wire = mode_pending_r & ~two_wire_r & cfg_eff.external_clock_select
    & OSC_B_IN;

  always_ff @(posedge CLK or negedge rst_n)
  begin
    if (!rst_n)
    begin
      two_wire_r <= 1'b0;
      mode_pending_r <= 1'b1;
    end
    else
    begin
      if (hard_release || WDT_RESET)
      begin
        mode_pending_r <= 1'b1;
      end
      else if (mode_pending_r)
      begin
        mode_pending_r <= 1'b0;
      end
      if (mode_pending_r)
      begin
        // pin b is the mode strap only while the external clock is chosen
        two_wire_r <= cfg_eff.external_clock_select & OSC_B_IN;
      end
    end
  end

  // ----------------------------------------------------------------
  // strap capture
  // ----------------------------------------------------------------
  afeio_strap_t straps_r;

  always_ff @(posedge CLK or negedge rst_n)
  begin
    if (!rst_n)
    begin
      straps_r <= STRAP_RESET;
    end
    else if (enter_two_wire || (WDT_RESET && two_wire_r))
    begin
      straps_r.strap_gain_bit_hi <= READY_IN;
      straps_r.strap_gain_bit_lo <= OSC_A_IN;
      straps_r.boost <= CS_N;
      straps_r.strap_oversample_bit_hi <= SDI;
      straps_r.strap_oversample_bit_lo <= HARD_RESET_N;
    end
  end

  // ----------------------------------------------------------------
  // clock chain
  // ----------------------------------------------------------------
  logic mclk_tick;
  logic mod_tick;
  logic dm_tick;
  logic dr_tick;
  logic [2:0] osr_code;
  logic [2:0] pre_cnt_r;
  logic [1:0] dm_cnt_r;
  logic [OSR_W-1:0] osr_cnt_r;

  // in two-wire mode the serial clock is the timebase, which the host keeps running
  assign mclk_tick = two_wire_r ? sck_rise
    : (cfg_eff.external_clock_select ? osca_rise : OSC_TICK);
  assign osr_code = two_wire_r
    ? {1'b0, straps_r.strap_oversample_bit_hi, straps_r.strap_oversample_bit_lo}
    : cfg_eff.osr;
  // hard reset stops distribution: no modulator tick leaves the prescaler
  assign mod_tick = mclk_tick & ~hard_rst
    & (pre_cnt_r >= afeio_prescale_last(cfg_eff.prescale));
  assign dm_tick = mod_tick & (dm_cnt_r == DIGITAL_SAMPLE_CLOCK_DIV_LAST);
  assign dr_tick = dm_tick & (osr_cnt_r >= afeio_osr_last(osr_code));

  always_ff @(posedge CLK or negedge rst_n)
  begin
    if (!rst_n)
    begin
      pre_cnt_r <= 3'h0;
      dm_cnt_r <= 2'h0;
      osr_cnt_r <= 13'h0000;
    end
    else if (hard_rst)
    begin
      pre_cnt_r <= 3'h0;
      dm_cnt_r <= 2'h0;
      osr_cnt_r <= 13'h0000;
    end
    else
    begin
      if (mod_tick)
      begin
        pre_cnt_r <= 3'h0;
      end
      else if (mclk_tick)
      begin
        pre_cnt_r <= pre_cnt_r + 3'h1;
      end
      if (mod_tick)
      begin
        dm_cnt_r <= dm_cnt_r + 2'h1;
      end
      if (dr_tick)
      begin
        osr_cnt_r <= 13'h0000;
      end
      else if (dm_tick)
      begin
        osr_cnt_r <= osr_cnt_r + 13'h0001;
      end
    end
  end

  // ----------------------------------------------------------------
  // conversion-ready pulse and pin
  // ----------------------------------------------------------------
  logic ready_low_r;
  logic [1:0] ready_cnt_r;

  // free-running from the clock chain; serial traffic never touches it
  always_ff @(posedge CLK or negedge rst_n)
  begin
    if (!rst_n)
    begin
      ready_low_r <= 1'b0;
      ready_cnt_r <= 2'h0;
    end
    else if (hard_rst)
    begin
      ready_low_r <= 1'b0;
      ready_cnt_r <= 2'h0;
    end
    else if (dr_tick)
    begin
      ready_low_r <= 1'b1;
      ready_cnt_r <= 2'h0;
    end
    else if (ready_low_r && mod_tick)
    begin
      // two modulator ticks make half a sample period
      if (ready_cnt_r == READY_LOW_LAST)
      begin
        ready_low_r <= 1'b0;
      end
      ready_cnt_r <= ready_cnt_r + 2'h1;
    end
  end

  always_ff @(posedge CLK or negedge rst_n)
  begin
    if (!rst_n)
    begin
      READY_OUT <= 1'b1;
      READY_OE_N <= 1'b1;
    end
    else
    begin
      READY_OUT <= ~ready_low_r;
      READY_OE_N <= two_wire_r | hard_rst
        | ~(cfg_eff.ready_pin_float_select | ready_low_r);
    end
  end

  // ----------------------------------------------------------------
  // two-wire output frame
  // ----------------------------------------------------------------
  logic [FRAME_BITS-1:0] frame_sh_r;
  logic [4:0] frame_left_r;
  logic frame_sdo_r;

  always_ff @(posedge CLK or negedge rst_n)
  begin
    if (!rst_n)
    begin
      frame_sh_r <= 24'h000000;
      frame_left_r <= 5'h00;
      frame_sdo_r <= 1'b0;
    end
    else if (!two_wire_r)
    begin
      frame_left_r <= 5'h00;
      frame_sdo_r <= 1'b0;
    end
    else if (dr_tick)
    begin
      frame_sh_r <= FRAME_DATA;
      frame_left_r <= FRAME_BITS_CNT;
    end
    else if (sck_fall && (frame_left_r != 5'h00))
    begin
      frame_sdo_r <= frame_sh_r[FRAME_BITS-1];
      frame_sh_r <= {frame_sh_r[FRAME_BITS-2:0], 1'b0};
      frame_left_r <= frame_left_r - 5'h01;
    end
  end

  // ----------------------------------------------------------------
  // serial-peripheral port
  // ----------------------------------------------------------------
  logic spi_sdo;
  logic spi_sdo_oe_n;

  afeio_spi_port u_spi (
    .clk(CLK),
    .rst_n(rst_n),
    .enable(~two_wire_r & ~hard_rst),
    .cs_n(CS_N),
    .sck_rise(sck_rise),
    .sck_fall(sck_fall),
    .sdi(SDI),
    .rd_data(RD_DATA),
    .sdo(spi_sdo),
    .sdo_oe_n(spi_sdo_oe_n),
    .cmd_valid(CMD_VALID),
    .cmd_byte(CMD_BYTE),
    .wr_valid(WR_VALID),
    .wr_byte(WR_BYTE),
    .rd_req(RD_REQ)
  );

  // ----------------------------------------------------------------
  // pin and status registers
  // ----------------------------------------------------------------
  always_ff @(posedge CLK or negedge rst_n)
  begin
    if (!rst_n)
    begin
      SDO_OUT <= 1'b0;
      SDO_OE_N <= 1'b1;
      OSC_ENABLE <= 1'b0;
      TWO_WIRE_MODE <= 1'b0;
      STRAPS <= STRAP_RESET;
      REGS_DEFAULT <= 1'b1;
      MODULATOR_TICK <= 1'b0;
      SAMPLE_TICK <= 1'b0;
      OUTPUT_RATE_TICK <= 1'b0;
      FRAME_LOAD <= 1'b0;
    end
    else
    begin
      SDO_OUT <= two_wire_r ? frame_sdo_r : spi_sdo;
      SDO_OE_N <= two_wire_r ? 1'b0 : (spi_sdo_oe_n | hard_rst);
      OSC_ENABLE <= ~two_wire_r & ~cfg_eff.external_clock_select;
      TWO_WIRE_MODE <= two_wire_r;
      STRAPS <= straps_r;
      REGS_DEFAULT <= hard_rst;
      MODULATOR_TICK <= mod_tick;
      SAMPLE_TICK <= dm_tick;
      OUTPUT_RATE_TICK <= dr_tick;
      FRAME_LOAD <= dr_tick & two_wire_r;
    end
  end

endmodule : afeio_top

// ---- bench/afeio_top_asserts.sv ----
// afeio_top_asserts: pin timing checks of the serial port and clock chain.
// assumes it is bound into afeio_top and sees its ports unchanged.
module afeio_top_asserts
  import afeio_pkg::*;
(
  input wire logic CLK,
  input wire logic RESET_N,
  input wire afeio_cfg_t CONFIG,
  input wire logic HARD_RESET_N,
  input wire logic CS_N,
  input wire logic READY_OUT,
  input wire logic READY_OE_N,
  input wire logic SDO_OE_N,
  input wire logic OSC_ENABLE,
  input wire logic TWO_WIRE_MODE,
  input wire logic OUTPUT_RATE_TICK,
  input wire logic FRAME_LOAD,
  input wire logic CMD_VALID,
  input wire logic WR_VALID
);
  timeunit 1ns;
  timeprecision 1ns;

  wire logic regs_ok = SDO_OE_N && !CMD_VALID && !WR_VALID;

  default clocking cb @(posedge CLK);
  endclocking
  default disable iff (!RESET_N);

  // ----------------------------------------------------------------
  // properties
  // ----------------------------------------------------------------
  property p_ready_float;
    (READY_OUT && !CONFIG.ready_pin_float_select)[*3] |-> READY_OE_N;
  endproperty
  a_ready_float: assert property (p_ready_float)
    else $error("ready pin driven while float selected");
  // serial traffic is deliberately absent from the antecedent
  property p_ready_fire;
    OUTPUT_RATE_TICK && !TWO_WIRE_MODE && HARD_RESET_N |-> ##[0:1] (!READY_OUT && !READY_OE_N);
  endproperty
  a_ready_fire: assert property (p_ready_fire)
    else $error("no ready pulse at output rate tick");
  property p_ready_2w;
    TWO_WIRE_MODE[*3] |-> READY_OE_N;
  endproperty
  a_ready_2w: assert property (p_ready_2w)
    else $error("ready pin driven in two-wire mode");
  property p_osc_off;
    (CONFIG.external_clock_select || TWO_WIRE_MODE)[*3] |-> !OSC_ENABLE;
  endproperty
  a_osc_off: assert property (p_osc_off)
    else $error("oscillator enabled with direct clock");
  property p_sdo_idle;
    (CS_N && !TWO_WIRE_MODE)[*4] |-> SDO_OE_N;
  endproperty
  a_sdo_idle: assert property (p_sdo_idle)
    else $error("serial out driven while deselected");
  property p_hard_block;
    (!HARD_RESET_N && !TWO_WIRE_MODE)[*3] |-> regs_ok;
  endproperty
  a_hard_block: assert property (p_hard_block)
    else $error("serial activity during hard reset");
  property p_cs_quiet;
    (CS_N && !TWO_WIRE_MODE)[*4] |-> !CMD_VALID && !WR_VALID;
  endproperty
  a_cs_quiet: assert property (p_cs_quiet)
    else $error("byte decoded while deselected");
  property p_cmd_frame;
    $rose(CMD_VALID) |-> !CS_N && HARD_RESET_N && !TWO_WIRE_MODE;
  endproperty
  a_cmd_frame: assert property (p_cmd_frame)
    else $error("command outside a selected frame");
  property p_frame;
    OUTPUT_RATE_TICK && TWO_WIRE_MODE |-> ##[0:1] FRAME_LOAD;
  endproperty
  a_frame: assert property (p_frame)
    else $error("no frame load at output rate tick");
  property p_duplex;
    !SDO_OE_N && !TWO_WIRE_MODE |-> !CMD_VALID && !WR_VALID;
  endproperty
  a_duplex: assert property (p_duplex)
    else $error("input decoded while output driven");
  c_read: cover property (!SDO_OE_N && !TWO_WIRE_MODE);
  c_write: cover property (WR_VALID);
  c_frame: cover property (FRAME_LOAD);
endmodule : afeio_top_asserts

bind afeio_top afeio_top_asserts afeio_top_asserts_inst (
  .CLK, .RESET_N, .CONFIG, .HARD_RESET_N, .CS_N, .READY_OUT, .READY_OE_N, .SDO_OE_N,
  .OSC_ENABLE, .TWO_WIRE_MODE, .OUTPUT_RATE_TICK, .FRAME_LOAD, .CMD_VALID, .WR_VALID
);

// ---- bench/afeio_host_model.sv ----
// afeio_host_model: host controller on the serial pins of the front end.
// assumes the bench calls its tasks from a process clocked by clk.
module afeio_host_model
(
  input wire logic clk,
  input wire logic sdo,
  input wire logic sdo_oe_n,
  output logic cs_n,
  output logic sck,
  output logic sdi
);
  timeunit 1ns;
  timeprecision 1ns;

  logic cpol = 1'h0;
  logic free_run = 1'h0;
  logic last_sdo = 1'h0;
  logic [1:0] fr_cnt = 2'h0;
  logic sdo_wire;

  // a released line reads as the inverse of its last level, never a lucky match
  assign sdo_wire = sdo_oe_n ? ~last_sdo : sdo;

  initial
  begin
    cs_n = 1'h1;
    sck = 1'h0;
    sdi = 1'h0;
  end

  always @(posedge clk)
  begin
    if (!sdo_oe_n)
      last_sdo <= sdo;
    if (free_run)
      fr_cnt <= fr_cnt + 2'h1;
    if (free_run && fr_cnt == 2'h3)
      sck <= ~sck;
  end

  task automatic hold(input int n);
    repeat (n) @(posedge clk);
  endtask : hold

  // data set while clock low, device samples the rise, host samples too
  task automatic bit_io(input logic b, output logic r);
    sck <= 1'h0;
    sdi <= b;
    hold(4);
    sck <= 1'h1;
    r = sdo_wire;
    hold(4);
  endtask : bit_io

  task automatic xfer(input logic [7:0] cmd, input logic [7:0] wd, output logic [7:0] rd);
    logic r;
    sck <= cpol;
    hold(2);
    cs_n <= 1'h0;
    hold(4);
    for (int i = 7; i >= 0; i--)
      bit_io(cmd[i], r);
    for (int i = 7; i >= 0; i--)
    begin
      bit_io(wd[i], r);
      rd[i] = r;
    end
    sck <= cpol;
    hold(2);
    cs_n <= 1'h1;
    hold(4);
  endtask : xfer

  task automatic noise();
    repeat (8)
    begin
      sck <= ~sck;
      sdi <= ~sdi;
      hold(3);
    end
    sck <= cpol;
    hold(1);
  endtask : noise

  task automatic pins(input logic c, input logic d);
    cs_n <= c;
    sdi <= d;
  endtask : pins
endmodule : afeio_host_model

// ---- bench/afeio_top_tb_top.sv ----
// afeio_top_tb_top: self-checking bench of the front end pin block.
// assumes the host model owns chip select, serial clock and data in.
`define CHK(got, exp) \
  begin \
    samples_checked++; \
    if ((got) !== (exp)) \
    begin \
      failures++; \
      $display("wrong value at %0t: got %0h expected %0h", $time, got, exp); \
    end \
  end

module afeio_top_tb_top
  import afeio_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ns;

  logic CLK = 1'h0;
  logic RESET_N = 1'h0;
  afeio_cfg_t CONFIG = CFG_DEFAULT;
  logic OSC_TICK = 1'h0;
  logic OSC_A_IN = 1'h0;
  logic OSC_B_IN = 1'h0;
  logic HARD_RESET_N = 1'h1;
  logic WDT_RESET = 1'h0;
  logic READY_IN = 1'h1;
  logic [FRAME_BITS-1:0] FRAME_DATA = 24'hC3A55A;
  logic [DATA_BITS-1:0] RD_DATA = 8'h96;
  wire logic CS_N, SCK, SDI;
  logic READY_OUT, READY_OE_N, SDO_OUT, SDO_OE_N, OSC_ENABLE, TWO_WIRE_MODE, REGS_DEFAULT;
  logic MODULATOR_TICK, SAMPLE_TICK, OUTPUT_RATE_TICK, FRAME_LOAD, CMD_VALID, WR_VALID;
  afeio_strap_t STRAPS;
  logic [CMD_BITS-1:0] CMD_BYTE;
  logic [DATA_BITS-1:0] WR_BYTE;
  logic [2:0] ticks;
  logic [1:0] osc_cnt = 2'h0;
  logic osc_run = 1'h0;
  int failures = 0;
  int samples_checked = 0;
  int n_drv = 0;
  int n_pls = 0;

  afeio_top afeio_top_inst (
    .CLK, .RESET_N, .CONFIG, .OSC_TICK, .OSC_A_IN, .OSC_B_IN, .HARD_RESET_N, .WDT_RESET,
    .CS_N, .SCK, .SDI, .READY_IN, .FRAME_DATA, .RD_DATA, .READY_OUT, .READY_OE_N, .SDO_OUT,
    .SDO_OE_N, .OSC_ENABLE, .TWO_WIRE_MODE, .STRAPS, .REGS_DEFAULT, .MODULATOR_TICK,
    .SAMPLE_TICK, .OUTPUT_RATE_TICK, .FRAME_LOAD, .CMD_VALID, .CMD_BYTE, .WR_VALID,
    .WR_BYTE, .RD_REQ()
  );
  afeio_host_model afeio_host_model_inst (
    .clk(CLK), .sdo(SDO_OUT), .sdo_oe_n(SDO_OE_N), .cs_n(CS_N), .sck(SCK), .sdi(SDI)
  );

  assign ticks = {OUTPUT_RATE_TICK, SAMPLE_TICK, MODULATOR_TICK};

  initial
  begin
    forever #25 CLK = ~CLK;
  end

  // crystal pulse and direct clock both give one master tick per 4 cycles
  always @(posedge CLK)
  begin
    osc_cnt <= osc_cnt + 2'h1;
    OSC_TICK <= (osc_cnt == 2'h3);
    if (osc_run && osc_cnt[0])
      OSC_A_IN <= ~OSC_A_IN;
    if (SDO_OE_N === 1'h0 && TWO_WIRE_MODE === 1'h0)
      n_drv <= n_drv + 1;
    if (CMD_VALID === 1'h1 || WR_VALID === 1'h1)
      n_pls <= n_pls + 1;
  end

  // ----------------------------------------------------------------
  // helpers
  // ----------------------------------------------------------------
  task automatic gap(input int k, output int n);
    int c;
    c = 0;
    while (ticks[k] !== 1'h1 && c < 5000)
    begin
      @(posedge CLK);
      c++;
    end
    n = 0;
    do
    begin
      @(posedge CLK);
      n++;
    end
    while (ticks[k] !== 1'h1 && n < 5000);
  endtask : gap

  task automatic test_done();
    $display("checks %0d failures %0d", samples_checked, failures);
    if (failures == 0 && samples_checked > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask : test_done

  // ----------------------------------------------------------------
  // tests
  // ----------------------------------------------------------------
  initial
  begin
    int per;
    int d0;
    logic [7:0] rd;
    logic [FRAME_BITS-1:0] frame;
    logic seen;
    CONFIG.external_clock_select <= 1'h0;
    CONFIG.osr <= 3'h0;
    repeat (20) @(posedge CLK);
    RESET_N <= 1'h1;
    repeat (6) @(posedge CLK);
    for (int p = 0; p < 4; p++)
    begin
      CONFIG.prescale <= p[1:0];
      gap(0, per);
      gap(0, per);
      `CHK(per, 4 << p);
    end
    `CHK(OSC_ENABLE, 1'h1);
    CONFIG.prescale <= 2'h0;
    gap(1, per);
    gap(1, per);
    `CHK(per, 16);
    gap(2, per);
    gap(2, per);
    `CHK(per, 512);
    per = 0;
    repeat (600)
    begin
      @(posedge CLK);
      if (READY_OUT === 1'h0)
        per++;
      else if (per > 0)
        break;
    end
    `CHK(per, 8);
    `CHK(READY_OE_N, 1'h1);
    CONFIG.ready_pin_float_select <= 1'h1;
    repeat (4) @(posedge CLK);
    `CHK({READY_OUT, READY_OE_N}, 2'h2);
    CONFIG.external_clock_select <= 1'h1;
    osc_run <= 1'h1;
    gap(0, per);
    gap(0, per);
    `CHK({per, OSC_ENABLE}, {32'd4, 1'h0});
    $display("clock chain test done");
    for (int m = 0; m < 2; m++)
    begin
      afeio_host_model_inst.cpol = m[0];
      d0 = n_drv;
      afeio_host_model_inst.xfer(8'h40, 8'h5A, rd);
      `CHK({CMD_BYTE, WR_BYTE, n_drv == d0}, {16'h405A, 1'h1});
      d0 = n_drv;
      afeio_host_model_inst.xfer(8'h41, 8'hFF, rd);
      `CHK({CMD_BYTE, rd, n_drv > d0}, {8'h41, RD_DATA, 1'h1});
    end
    d0 = n_pls;
    afeio_host_model_inst.noise();
    `CHK(n_pls == d0, 1'h1);
    HARD_RESET_N <= 1'h0;
    repeat (4) @(posedge CLK);
    afeio_host_model_inst.xfer(8'h40, 8'h3C, rd);
    `CHK({n_pls == d0, REGS_DEFAULT}, 2'h3);
    seen = 1'h0;
    repeat (40)
    begin
      @(posedge CLK);
      seen |= |ticks;
    end
    `CHK(seen, 1'h0);
    HARD_RESET_N <= 1'h1;
    // let the mode resample on hard reset release finish before moving the pin
    repeat (4) @(posedge CLK);
    $display("serial test done");
    OSC_B_IN <= 1'h1;
    osc_run <= 1'h0;
    repeat (10) @(posedge CLK);
    `CHK(TWO_WIRE_MODE, 1'h0);
    OSC_A_IN <= 1'h1;
    READY_IN <= 1'h0;
    afeio_host_model_inst.pins(1'h0, 1'h1);
    WDT_RESET <= 1'h1;
    @(posedge CLK);
    WDT_RESET <= 1'h0;
    repeat (6) @(posedge CLK);
    `CHK({TWO_WIRE_MODE, STRAPS, OSC_ENABLE}, {1'h1, 5'h0B, 1'h0});
    afeio_host_model_inst.free_run <= 1'h1;
    @(posedge FRAME_LOAD);
    for (int i = FRAME_BITS - 1; i >= 0; i--)
    begin
      @(negedge SCK);
      @(posedge SCK);
      frame[i] = SDO_OUT;
    end
    `CHK(frame, FRAME_DATA);
    `CHK({SDO_OE_N, READY_OE_N}, 2'h1);
    OSC_B_IN <= 1'h0;
    repeat (10) @(posedge CLK);
    `CHK(TWO_WIRE_MODE, 1'h1);
    $display("two-wire test done");
    test_done();
  end

  initial
  begin
    repeat (60000) @(posedge CLK);
    failures++;
    $display("wrong value at %0t: watchdog expired", $time);
    test_done();
  end
endmodule : afeio_top_tb_top
